// ---- core/sspsc_core.sv ----
// shared sram port control, address mapping and boot control word
// assumes a synchronous host register port and download status inputs
`default_nettype none
`include "sspsc_defs.svh"
module sspsc_core #(
  parameter int ADDR_W = 16,
  parameter int NGCK = 8,
  parameter int NFCK = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic procInReset,
  input wire logic bootLoad,
  input wire logic [63:0] bootWord,
  input wire logic downloadActive,
  input wire logic downloadStart,
  input wire logic configDonePin,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  output sspsc_pkg::sspsc_mode_e configMode,
  input wire logic procMemWr,
  input wire logic procMemRd,
  input wire logic [13:0] procDataAddr,
  input wire logic [7:0] procWdata,
  output logic procDataHit,
  input wire logic progFetch,
  input wire logic [13:0] progAddr,
  output logic [ADDR_W-1:0] progLoAddr,
  output logic [ADDR_W-1:0] progHiAddr,
  output logic progHiValid,
  input wire logic [ADDR_W-1:0] fabAddr,
  input wire logic [7:0] fabWdata,
  input wire logic fabWr,
  input wire logic fabClkIn,
  output logic bPortEn,
  output logic [ADDR_W-1:0] bAddr,
  output logic [7:0] bWdata,
  output logic bWr,
  output logic bRdEn,
  output logic bClk,
  output logic aWr,
  output logic aRd,
  output logic [ADDR_W-1:0] aAddr,
  output logic [7:0] aWdata,
  output logic progWriteProtect,
  output logic cascadeSelectUsed,
  output logic checkPinForConfig,
  output logic lockoutAbort,
  output logic initPinAssert,
  output logic donePinRelease,
  input wire logic global_output_float_pin,
  output logic userIoFloat,
  output logic configClockRun,
  input wire logic [NGCK-1:0] global_clock_input,
  input wire logic [NFCK-1:0] fast_clock_input,
  output logic [NGCK+NFCK-1:0] clkBufGated,
  output logic debugChainsEn,
  output logic tapChainsEn,
  output logic globalSetResetHold
);
  import sspsc_pkg::*;

  logic [63:0] boot_loaded_control_word_ff;
  logic [7:0] processor_side_control_ff;
  logic lockWrites_ff;
  logic [7:0] regRdata_ff;
  logic donePrev_ff;
  logic dlHold_ff;
  logic [NGCK+NFCK-1:0] gate_ff;
  logic portEffective;
  logic patchMode;
  logic [ADDR_W-1:0] procDataWide;
  sspsc_size_t dataSize;

  // reserved bits are stored verbatim and only read back through the cw registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      boot_loaded_control_word_ff <= 64'h0;
    end else if (bootLoad && !lockWrites_ff) begin
      boot_loaded_control_word_ff <= bootWord;
    end
  end

  // lockout stays until reset, so a later load cannot clear it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lockWrites_ff <= 1'b0;
    end else if (!downloadActive && boot_loaded_control_word_ff[`SSPSC_CW_LOCK]) begin
      lockWrites_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      processor_side_control_ff <= 8'h0;
    end else if (procInReset) begin
      processor_side_control_ff[`SSPSC_PSC_INV] <= 1'b0;
    end else if (regWr && regAddr == `SSPSC_REG_PSC) begin
      processor_side_control_ff <= regWdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdata_ff <= 8'h0;
    end else if (regRd) begin
      unique case (regAddr)
        `SSPSC_REG_PSC: regRdata_ff <= processor_side_control_ff;
        `SSPSC_REG_STAT: regRdata_ff <= {4'h0, lockWrites_ff, dlHold_ff, portEffective,
                                         patchMode};
        default: begin
          if (regAddr >= `SSPSC_REG_CW0 && regAddr < `SSPSC_REG_CW0 + 8'h08) begin
            regRdata_ff <= boot_loaded_control_word_ff[8*regAddr[2:0] +: 8];
          end else begin
            regRdata_ff <= 8'h0;
          end
        end
      endcase
    end else begin
      regRdata_ff <= 8'h0;
    end
  end
  assign regRdata = regRdata_ff;

  always_comb begin
    unique case ({mode_select_high, mode_select_low})
      2'b00: configMode = SSPSC_MASTER_SERIAL;
      2'b01: configMode = SSPSC_SLAVE_CASCADE;
      2'b10: configMode = SSPSC_TEST_A;
      default: configMode = SSPSC_TEST_B;
    endcase
  end

  assign patchMode = processor_side_control_ff[`SSPSC_PSC_PATCH];
  assign portEffective = boot_loaded_control_word_ff[`SSPSC_CW_PORT_EN]
                         ^ processor_side_control_ff[`SSPSC_PSC_INV];
  // fabric contention in patch mode is left to software to avoid
  assign bPortEn = portEffective && !downloadActive;
  assign bRdEn = bPortEn;

  assign dataSize = boot_loaded_control_word_ff[`SSPSC_CW_SIZE_LO +: 2];
  always_comb begin
    unique case (procDataAddr[13:12])
      2'b00: procDataHit = 1'b1;
      2'b01: procDataHit = dataSize != 2'b00;
      2'b10: procDataHit = dataSize[1];
      default: procDataHit = dataSize == 2'b11;
    endcase
  end

  assign procDataWide = ADDR_W'(procDataAddr);
  // a side and b side run independently, no arbitration here
  assign aWr = procMemWr && procDataHit && !patchMode;
  assign aRd = procMemRd && procDataHit && !patchMode;
  assign aAddr = procDataWide;
  assign aWdata = procWdata;

  // patch mode steers stores and loads onto the b side
  always_comb begin
    if (patchMode) begin
      bAddr = procDataWide;
      bWdata = procWdata;
      bWr = procMemWr;
    end else begin
      bAddr = fabAddr;
      bWdata = fabWdata;
      bWr = fabWr && bPortEn;
    end
  end
  assign progWriteProtect = !patchMode && |{boot_loaded_control_word_ff[`SSPSC_CW_WPROT1],
                            boot_loaded_control_word_ff[`SSPSC_CW_WPROT0]};

  always_comb begin
    progLoAddr = '0;
    progHiAddr = '0;
    progHiValid = 1'b0;
    if (progFetch && progAddr >= `SSPSC_PROG_HI_BASE) begin
      progLoAddr = ADDR_W'({`SSPSC_BLK02, progAddr[`SSPSC_BLK_W-1:0]});
      progHiAddr = ADDR_W'({`SSPSC_BLK03, progAddr[`SSPSC_BLK_W-1:0]});
      progHiValid = 1'b1;
    end else if (progFetch && progAddr >= `SSPSC_PROG_LO_BASE) begin
      progLoAddr = ADDR_W'({`SSPSC_BLK04, progAddr[`SSPSC_BLK_W-1:0]});
      progHiAddr = ADDR_W'({`SSPSC_BLK05, progAddr[`SSPSC_BLK_W-1:0]});
      progHiValid = 1'b1;
    end
  end

  assign bClk = fabClkIn ^ boot_loaded_control_word_ff[`SSPSC_CW_FCLK_POL];

  assign cascadeSelectUsed = downloadActive
                             && !boot_loaded_control_word_ff[`SSPSC_CW_CASC_OFF];
  assign checkPinForConfig = !boot_loaded_control_word_ff[`SSPSC_CW_CHECK_OFF];
  assign lockoutAbort = downloadStart && lockWrites_ff;
  assign initPinAssert = lockoutAbort;
  assign donePinRelease = lockoutAbort;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      donePrev_ff <= 1'b0;
    end else begin
      donePrev_ff <= configDonePin;
    end
  end

  // hold ends on the done pin rising edge, not on download flag
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dlHold_ff <= 1'b0;
    end else if (configDonePin && !donePrev_ff) begin
      dlHold_ff <= 1'b0;
    end else if (downloadActive) begin
      dlHold_ff <= 1'b1;
    end
  end
  assign globalSetResetHold = dlHold_ff && boot_loaded_control_word_ff[`SSPSC_CW_GSR];
  assign userIoFloat = (dlHold_ff && boot_loaded_control_word_ff[`SSPSC_CW_IOFLOAT])
                       || (boot_loaded_control_word_ff[`SSPSC_CW_FLOAT_EN]
                           && global_output_float_pin);

  assign configClockRun = downloadActive || (configMode == SSPSC_MASTER_SERIAL
                          && boot_loaded_control_word_ff[`SSPSC_CW_CONFIG_CLOCK_PIN_RUN]);

  // gate bits registered on ref_clk, clock inputs or'd in directly; a true buffer would use each own edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_ff <= '0;
    end else begin
      gate_ff <= {boot_loaded_control_word_ff[`SSPSC_CW_FCK_LO +: NFCK],
                  boot_loaded_control_word_ff[`SSPSC_CW_GCK_LO +: NGCK]}
                 & {(NGCK+NFCK){downloadActive}};
    end
  end
  assign clkBufGated = {fast_clock_input, global_clock_input} | gate_ff;

  assign tapChainsEn = boot_loaded_control_word_ff[`SSPSC_CW_TAP_EN];
  assign debugChainsEn = tapChainsEn && boot_loaded_control_word_ff[`SSPSC_CW_DBG_EN]
                         && !boot_loaded_control_word_ff[`SSPSC_CW_LOCK];
endmodule
`default_nettype wire

// ---- pkg/sspsc_defs.svh ----
// constants for the shared sram port and system control block
// assumes inclusion by bare name from core and bench files
`ifndef SSPSC_DEFS_SVH
`define SSPSC_DEFS_SVH
`define SSPSC_REG_PSC 8'h3a
`define SSPSC_REG_CW0 8'h40
`define SSPSC_REG_STAT 8'h48
`define SSPSC_PSC_PATCH 1
`define SSPSC_PSC_INV 3
`define SSPSC_CW_CASC_OFF 2
`define SSPSC_CW_CHECK_OFF 3
`define SSPSC_CW_LOCK 4
`define SSPSC_CW_FLOAT_EN 6
`define SSPSC_CW_CONFIG_CLOCK_PIN_RUN 13
`define SSPSC_CW_GCK_LO 16
`define SSPSC_CW_FCK_LO 24
`define SSPSC_CW_DBG_EN 26
`define SSPSC_CW_TAP_EN 27
`define SSPSC_CW_GSR 30
`define SSPSC_CW_IOFLOAT 31
`define SSPSC_CW_WPROT0 36
`define SSPSC_CW_WPROT1 37
`define SSPSC_CW_FCLK_POL 38
`define SSPSC_CW_SIZE_LO 40
`define SSPSC_CW_PORT_EN 63
`define SSPSC_BLK_W 11
`define SSPSC_PROG_HI_BASE 14'h3800
`define SSPSC_PROG_LO_BASE 14'h3000
`define SSPSC_BLK02 4'h2
`define SSPSC_BLK03 4'h3
`define SSPSC_BLK04 4'h4
`define SSPSC_BLK05 4'h5
`endif

// ---- pkg/sspsc_pkg.sv ----
// types for the shared sram port and system control block
// assumes nothing beyond the defs header
`default_nettype none
package sspsc_pkg;
  typedef enum logic [3:0] {
    SSPSC_MASTER_SERIAL = 4'h1,
    SSPSC_SLAVE_CASCADE = 4'h2,
    SSPSC_TEST_A = 4'h4,
    SSPSC_TEST_B = 4'h8
  } sspsc_mode_e;
  typedef logic [1:0] sspsc_size_t;
endpackage
`default_nettype wire

// ---- bench/sspsc_fabric_model.sv ----
// fabric user logic model on the b port of the shared sram
// assumes the bench asks for single writes through req
`default_nettype none
module sspsc_fabric_model (
  input wire logic ref_clk,
  input wire logic bPortEn,
  input wire logic req,
  input wire logic [15:0] reqAddr,
  input wire logic procWr,
  output logic [15:0] fabAddr,
  output logic [7:0] fabWdata,
  output logic fabWr,
  output logic fabClkIn
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {fabAddr, fabWdata, fabWr, fabClkIn} = '0;
  end
  always @(posedge ref_clk) begin
    // clock stands still while the port is off
    fabClkIn <= bPortEn & ~fabClkIn;
    // coarse priority: a processor write wins the whole cycle
    fabWr <= req & bPortEn & ~procWr;
    // released lines show the inverse, never the last value
    fabAddr <= req ? reqAddr : ~fabAddr;
    fabWdata <= req ? reqAddr[7:0] ^ 8'h5a : ~fabWdata;
  end
endmodule
`default_nettype wire

// ---- bench/sspsc_core_properties.sv ----
// checker for the shared sram port and control block
// assumes bind onto sspsc_core, one clock domain
`default_nettype none
`include "sspsc_defs.svh"
module sspsc_core_properties #(
  parameter int ADDR_W = 16,
  parameter int NGCK = 8,
  parameter int NFCK = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic procInReset,
  input wire logic downloadActive,
  input wire logic mode_select_low,
  input wire logic mode_select_high,
  input wire sspsc_pkg::sspsc_mode_e configMode,
  input wire logic progFetch,
  input wire logic [13:0] progAddr,
  input wire logic [ADDR_W-1:0] progLoAddr,
  input wire logic [ADDR_W-1:0] fabAddr,
  input wire logic [ADDR_W-1:0] bAddr,
  input wire logic bPortEn,
  input wire logic bRdEn,
  input wire logic aWr,
  input wire logic progWriteProtect,
  input wire logic [NGCK-1:0] global_clock_input,
  input wire logic [NGCK+NFCK-1:0] clkBufGated
);
  import sspsc_pkg::*;
  logic patch_ff;
  // own copy of the patch bit, the core's is not visible here
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) patch_ff <= 1'b0;
    else if (regWr && regAddr == `SSPSC_REG_PSC) patch_ff <= regWdata[`SSPSC_PSC_PATCH];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  port_off_dl_a: assert property (downloadActive |-> !bPortEn) else $error("port on");
  read_open_a: assert property (bPortEn |-> bRdEn) else $error("read shut");
  patch_free_a: assert property (patch_ff |-> !aWr && !progWriteProtect)
    else $error("patch not free");
  inv_clear_a: assert property (procInReset[*2] ##0 (regRd && regAddr == `SSPSC_REG_PSC)
    |=> !regRdata[`SSPSC_PSC_INV]) else $error("invert kept");
  flat_map_a: assert property (bPortEn && !patch_ff |-> bAddr == fabAddr)
    else $error("b address");
  prog_split_a: assert property (progFetch && progAddr[13:12] == 2'h3 |-> progLoAddr ==
    ADDR_W'({progAddr[11] ? `SSPSC_BLK02 : `SSPSC_BLK04, progAddr[10:0]})) else $error("prog");
  mode_map_a: assert property (mode_select_high ?
    configMode inside {SSPSC_TEST_A, SSPSC_TEST_B} :
    configMode == (mode_select_low ? SSPSC_SLAVE_CASCADE : SSPSC_MASTER_SERIAL)) else $error("mode");
  gate_high_a: assert property (|global_clock_input |->
    ~|(global_clock_input & ~clkBufGated[NGCK-1:0])) else $error("gate low");
  cover property (downloadActive && clkBufGated[0]);
  cover property (patch_ff && !bPortEn);
  cover property (bPortEn && !patch_ff && regRd);
endmodule
bind sspsc_core sspsc_core_properties #(.ADDR_W(ADDR_W), .NGCK(NGCK), .NFCK(NFCK)) chk (.*);
`default_nettype wire

// ---- bench/tb.sv ----
// self-checking bench for the shared sram port and control block
// assumes core, checker and fabric model compiled first
`default_nettype none
`include "sspsc_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import sspsc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst, regWr, regRd, procInReset, bootLoad, downloadActive, downloadStart, configDonePin;
  logic mode_select_low, mode_select_high, procMemWr, procMemRd, progFetch, req, fabWr;
  logic global_output_float_pin, fabClkIn, procDataHit, progHiValid, bPortEn, bWr, bRdEn;
  logic bClk, aWr, aRd, progWriteProtect, cascadeSelectUsed, checkPinForConfig, lockoutAbort;
  logic initPinAssert, donePinRelease, userIoFloat, configClockRun, debugChainsEn;
  logic tapChainsEn, globalSetResetHold;
  logic [7:0] regAddr, regWdata, regRdata, procWdata, fabWdata, bWdata, aWdata;
  logic [7:0] global_clock_input;
  logic [1:0] fast_clock_input;
  logic [9:0] clkBufGated;
  logic [13:0] procDataAddr, progAddr;
  logic [15:0] fabAddr, progLoAddr, progHiAddr, bAddr, aAddr;
  logic [63:0] bootWord, cw;
  sspsc_mode_e configMode;
  int fail_count = 0;
  int checked = 0;
  sspsc_core DUT (.*);
  sspsc_fabric_model fab (.ref_clk, .bPortEn, .req, .reqAddr({2'b00, procDataAddr}),
    .procWr(procMemWr), .fabAddr, .fabWdata, .fabWr, .fabClkIn);
  always #2.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk) regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk) regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk) regRd <= 1'b0;
    #1 chk(regRdata, e);
  endtask
  task automatic boot(input logic [63:0] w);
    @(posedge ref_clk) bootLoad <= 1'b1;
    bootWord <= w;
    @(posedge ref_clk) bootLoad <= 1'b0;
  endtask
  task automatic close_out();
    $display("mismatches %0d, checks %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {regWr, regRd, procInReset, bootLoad, downloadActive, downloadStart, configDonePin} = '0;
    {mode_select_low, mode_select_high, procMemWr, procMemRd, progFetch, req} = '0;
    {global_output_float_pin, regAddr, regWdata, procWdata, bootWord, cw} = '0;
    {procDataAddr, progAddr, global_clock_input, fast_clock_input} = '0;
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`SSPSC_REG_PSC, 8'h00);
    rd(8'h7f, 8'h00);
    procMemRd <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      cw = 64'h8000_0010_0101_000f | (64'(s) << 40);
      boot(cw);
      for (int k = 0; k < 4; k++) begin
        @(posedge ref_clk) procDataAddr <= 14'(k << 12);
        #1 chk(procDataHit, k <= s);
      end
    end
    wr(8'h40, 8'hff);
    for (int n = 0; n < 8; n++) rd(8'h40 + 8'(n), cw[8*n +: 8]);
    chk({bPortEn, bRdEn, progWriteProtect}, 3'b111);
    @(posedge ref_clk) procDataAddr <= 14'h0123;
    req <= 1'b1;
    @(posedge ref_clk) req <= 1'b0;
    #1 chk({bWr, bAddr, bWdata, aRd}, {1'b1, 16'h0123, 8'h79, 1'b1});
    wr(`SSPSC_REG_PSC, 8'h08);
    #1 chk(bPortEn, 1'b0);
    rd(`SSPSC_REG_PSC, 8'h08);
    procInReset <= 1'b1;
    rd(`SSPSC_REG_PSC, 8'h00);
    procInReset <= 1'b0;
    #1 chk(bPortEn, 1'b1);
    wr(`SSPSC_REG_PSC, 8'h0a);
    procMemWr <= 1'b1;
    procMemRd <= 1'b0;
    #1 chk({aWr, bPortEn, progWriteProtect}, 3'b000);
    procMemWr <= 1'b0;
    wr(`SSPSC_REG_PSC, 8'h00);
    progFetch <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) progAddr <= 14'h3055 | 14'(i << 11);
      #1 chk(progLoAddr, i ? 16'h1055 : 16'h2055);
      chk({progHiValid, progHiAddr}, {1'b1, i ? 16'h1855 : 16'h2855});
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk) {mode_select_high, mode_select_low} <= 2'(m);
      #1 if (m < 2) chk(configMode, m ? SSPSC_SLAVE_CASCADE : SSPSC_MASTER_SERIAL);
      else chk(configMode, m == 2 ? SSPSC_TEST_A : SSPSC_TEST_B);
    end
    // float enable, clock run, debug, tap, hold, io float and clock polarity bits
    boot(cw | 64'h0000_0040_cc00_2040);
    @(posedge ref_clk) {mode_select_high, mode_select_low} <= 2'b00;
    global_output_float_pin <= 1'b1;
    #1 chk({configClockRun, debugChainsEn, tapChainsEn}, 3'b111);
    chk({userIoFloat, bClk ^ fabClkIn}, 2'b11);
    @(posedge ref_clk) global_output_float_pin <= 1'b0;
    #1 chk(userIoFloat, 1'b0);
    @(posedge ref_clk) downloadActive <= 1'b1;
    global_clock_input <= 8'h01;
    fast_clock_input <= 2'b01;
    @(posedge ref_clk) global_clock_input <= 8'h00;
    fast_clock_input <= 2'b00;
    repeat (3) @(posedge ref_clk);
    #1 chk({bPortEn, cascadeSelectUsed, checkPinForConfig, clkBufGated}, 13'h0101);
    chk({globalSetResetHold, userIoFloat}, 2'b11);
    downloadActive <= 1'b0;
    configDonePin <= 1'b1;
    @(posedge ref_clk);
    #1 chk({globalSetResetHold, userIoFloat}, 2'b00);
    boot(cw | 64'h10);
    boot(64'h0);
    rd(8'h40, 8'h1f);
    rd(`SSPSC_REG_STAT, 8'h0a);
    @(posedge ref_clk) downloadStart <= 1'b1;
    downloadActive <= 1'b1;
    #1 chk({lockoutAbort, initPinAssert, donePinRelease}, 3'b111);
    close_out();
  end
  initial begin
    #20000;
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
